// [src/hltmr_pkg.sv]
// Shared constants for the hardware limit period timer
package hltmr_pkg;
  localparam int CNT_W = 8;
  localparam int MODE_W = 5;
  localparam int PRE_W = 3;
  localparam int POST_W = 4;
  localparam int PRE_CNT_W = 7;
  localparam int SYNC_STAGES = 3;
  localparam int ON_SYNC_STAGES = 2;
  localparam int CLK_FREQ_HZ = 40000000;
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
  localparam logic [POST_W-1:0] POST_RST = 4'h0;
  localparam logic [PRE_CNT_W-1:0] PRE_RST = 7'h00;
  // Mode codes
  localparam logic [MODE_W-1:0] MODE_SW_GATE = 5'h00;
  localparam logic [MODE_W-1:0] MODE_GATE_HI_STOP = 5'h01;
  localparam logic [MODE_W-1:0] MODE_GATE_LO_STOP = 5'h02;
  localparam logic [MODE_W-1:0] MODE_HL_ANY_EDGE = 5'h03;
  localparam logic [MODE_W-1:0] MODE_HL_RISE = 5'h04;
  localparam logic [MODE_W-1:0] MODE_HL_FALL = 5'h05;
  localparam logic [MODE_W-1:0] MODE_HL_LOW_LVL = 5'h06;
  localparam logic [MODE_W-1:0] MODE_HL_HIGH_LVL = 5'h07;
  localparam logic [MODE_W-1:0] MODE_OS_SW = 5'h08;
  localparam logic [MODE_W-1:0] MODE_OS_RISE = 5'h09;
  localparam logic [MODE_W-1:0] MODE_OS_FALL = 5'h0A;
  localparam logic [MODE_W-1:0] MODE_OS_ANY = 5'h0B;
  localparam logic [MODE_W-1:0] MODE_OSHL_RISE = 5'h0C;
  localparam logic [MODE_W-1:0] MODE_OSHL_FALL = 5'h0D;
  localparam logic [MODE_W-1:0] MODE_OSHL_RISE_LOW = 5'h0E;
  localparam logic [MODE_W-1:0] MODE_OSHL_FALL_HIGH = 5'h0F;
  localparam logic [MODE_W-1:0] MODE_MONO_RISE = 5'h11;
  localparam logic [MODE_W-1:0] MODE_MONO_FALL = 5'h12;
  localparam logic [MODE_W-1:0] MODE_MONO_ANY = 5'h13;
  localparam logic [MODE_W-1:0] MODE_LVL_OS_HIGH = 5'h16;
  localparam logic [MODE_W-1:0] MODE_LVL_OS_LOW = 5'h17;
  typedef enum logic {HLTMR_IDLE, HLTMR_ACTIVE} hltmr_run_type;
endpackage : hltmr_pkg

// [src/hltmr_sync.sv]
// Three-stage synchroniser with agreement filter for the external reset pin
`timescale 1ns/1ps
`default_nettype none
module hltmr_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Pin in, filtered level out
  input wire logic async_in,
  output logic level_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Level changes once stages two and three agree
  always_ff @(posedge clk) begin
    if (srst) begin
      level_out <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      level_out <= s3_reg;
    end
  end
endmodule : hltmr_sync
`default_nettype wire

// [src/hltmr_top.sv]
// Period timer with hardware limit, one-shot and monostable control
//
// Behaviour
// - Software gate counts while enabled, wraps at period
// - Hardware gate halts on external high or low
// - Edge hardware limit clears count on selected edge
// - Level hardware limit holds count at reset level
// - Level limit ignores external signal while disabled
// - Level reset and release act four clocks later
// - Software one-shot clears enable at period match
// - Software one-shot pauses and resumes mid-cycle
// - Edge one-shot starts on edge, clears enable
// - Edge start modes need fresh edge after disable
// - Edge limit one-shot starts, then resets on edges
// - After edge reset, counting resumes automatically
// - Edges ignored until enable bit is set
// - One-shot match clears enable, stops at zero
// - Monostable match stops at zero, enable kept
// - Level one-shot: start on level, reset opposite
// - Edge start with opposite level reset
// - Postscaled match raises flag, gated by enable
// - Enable synchronised two cycles, external signal four cycles
// - Zero prescale and postscale give 1:1 ratios
// - Edge monostable starts on edge, stops at match
`timescale 1ns/1ps
`default_nettype none
module hltmr_top #(
  parameter int CNT_W = hltmr_pkg::CNT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Enable bit access
  input wire logic on_wr,
  input wire logic on_wdata,
  output logic timer_on,
  // Configuration
  input wire logic [hltmr_pkg::MODE_W-1:0] mode_select,
  input wire logic [CNT_W-1:0] period_value,
  input wire logic [hltmr_pkg::PRE_W-1:0] prescale_select,
  input wire logic [hltmr_pkg::POST_W-1:0] postscale_select,
  // Interrupt flag
  input wire logic timer_irq_enable,
  input wire logic irq_flag_clr,
  output logic irq_flag,
  output logic timer_irq,
  // External reset pin
  input wire logic ext_reset_signal,
  // Status
  output logic [CNT_W-1:0] count_value,
  output logic postscaled_pulse,
  output logic period_match
);
  logic on_d1_reg;
  logic on_d2_reg;
  logic on_eff;
  logic on_prev_reg;
  logic ers_level;
  logic ers_prev_reg;
  logic rise_pend_reg;
  logic fall_pend_reg;
  logic on_rise_pend_reg;
  logic rise_p;
  logic fall_p;
  logic on_rise_p;
  logic [hltmr_pkg::PRE_CNT_W-1:0] pre_cnt_reg;
  logic [7:0] pre_span;
  logic tick;
  logic [hltmr_pkg::POST_W-1:0] post_cnt_reg;
  hltmr_pkg::hltmr_run_type run_reg;
  logic match;
  logic match_ev;
  logic hw_clr_on;
  // Decoded mode
  logic free_mode;
  logic gate;
  logic hw_rst;
  logic start_ev;
  logic keep_on_rst;
  logic clears_on;
  logic reserved;

  // Counter constants at the counter's own width
  localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(hltmr_pkg::CNT_RST);
  localparam logic [CNT_W-1:0] CNT_STEP = CNT_W'(8'h01);

  // Enable bit; a software write beats the hardware clear
  always_ff @(posedge clk) begin
    if (srst) begin
      timer_on <= 1'b0;
    end else if (on_wr) begin
      timer_on <= on_wdata;
    end else if (hw_clr_on) begin
      timer_on <= 1'b0;
    end
  end

  // Enable reaches the counter two cycles late
  always_ff @(posedge clk) begin
    if (srst) begin
      on_d1_reg <= 1'b0;
      on_d2_reg <= 1'b0;
    end else begin
      on_d1_reg <= timer_on;
      on_d2_reg <= on_d1_reg;
    end
  end

  // Stale enable is masked once hardware has cleared it
  assign on_eff = on_d2_reg & timer_on;

  hltmr_sync u_sync (
    .clk(clk),
    .srst(srst),
    .async_in(ext_reset_signal),
    .level_out(ers_level)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      ers_prev_reg <= 1'b0;
      on_prev_reg <= 1'b0;
    end else begin
      ers_prev_reg <= ers_level;
      on_prev_reg <= on_eff;
    end
  end

  // Prescaler: tick every 2^prescale_select clocks
  assign pre_span = 8'h01 << prescale_select;
  assign tick = (pre_cnt_reg == pre_span[hltmr_pkg::PRE_CNT_W-1:0] - 7'h01);

  always_ff @(posedge clk) begin
    if (srst) begin
      pre_cnt_reg <= hltmr_pkg::PRE_RST;
    end else if (tick) begin
      pre_cnt_reg <= hltmr_pkg::PRE_RST;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 7'h01;
    end
  end

  // External edges held until the next tick, used there once
  always_ff @(posedge clk) begin
    if (srst) begin
      rise_pend_reg <= 1'b0;
      fall_pend_reg <= 1'b0;
    end else begin
      rise_pend_reg <= rise_p & ~tick;
      fall_pend_reg <= fall_p & ~tick;
    end
  end

  // Enable rise held the same way for the software one-shot
  always_ff @(posedge clk) begin
    if (srst) begin
      on_rise_pend_reg <= 1'b0;
    end else begin
      on_rise_pend_reg <= on_rise_p & ~tick;
    end
  end

  assign rise_p = rise_pend_reg | (ers_level & ~ers_prev_reg);
  assign fall_p = fall_pend_reg | (~ers_level & ers_prev_reg);
  assign on_rise_p = on_rise_pend_reg | (on_eff & ~on_prev_reg);

  // Mode decode
  always_comb begin
    free_mode = 1'b0;
    gate = 1'b1;
    hw_rst = 1'b0;
    start_ev = 1'b0;
    keep_on_rst = 1'b0;
    clears_on = 1'b1;
    reserved = 1'b0;
    case (mode_select)
      hltmr_pkg::MODE_SW_GATE: begin
        free_mode = 1'b1;
      end
      hltmr_pkg::MODE_GATE_HI_STOP: begin
        free_mode = 1'b1;
        gate = ~ers_level;
      end
      hltmr_pkg::MODE_GATE_LO_STOP: begin
        free_mode = 1'b1;
        gate = ers_level;
      end
      hltmr_pkg::MODE_HL_ANY_EDGE: begin
        free_mode = 1'b1;
        hw_rst = rise_p | fall_p;
      end
      hltmr_pkg::MODE_HL_RISE: begin
        free_mode = 1'b1;
        hw_rst = rise_p;
      end
      hltmr_pkg::MODE_HL_FALL: begin
        free_mode = 1'b1;
        hw_rst = fall_p;
      end
      hltmr_pkg::MODE_HL_LOW_LVL: begin
        free_mode = 1'b1;
        hw_rst = ~ers_level;
      end
      hltmr_pkg::MODE_HL_HIGH_LVL: begin
        free_mode = 1'b1;
        hw_rst = ers_level;
      end
      hltmr_pkg::MODE_OS_SW: begin
        start_ev = on_rise_p;
      end
      hltmr_pkg::MODE_OS_RISE: begin
        start_ev = rise_p;
      end
      hltmr_pkg::MODE_OS_FALL: begin
        start_ev = fall_p;
      end
      hltmr_pkg::MODE_OS_ANY: begin
        start_ev = rise_p | fall_p;
      end
      hltmr_pkg::MODE_OSHL_RISE: begin
        start_ev = rise_p;
        hw_rst = rise_p;
        keep_on_rst = 1'b1;
      end
      hltmr_pkg::MODE_OSHL_FALL: begin
        start_ev = fall_p;
        hw_rst = fall_p;
        keep_on_rst = 1'b1;
      end
      hltmr_pkg::MODE_OSHL_RISE_LOW: begin
        start_ev = rise_p;
        hw_rst = ~ers_level;
      end
      hltmr_pkg::MODE_OSHL_FALL_HIGH: begin
        start_ev = fall_p;
        hw_rst = ers_level;
      end
      hltmr_pkg::MODE_MONO_RISE: begin
        start_ev = rise_p;
        clears_on = 1'b0;
      end
      hltmr_pkg::MODE_MONO_FALL: begin
        start_ev = fall_p;
        clears_on = 1'b0;
      end
      hltmr_pkg::MODE_MONO_ANY: begin
        start_ev = rise_p | fall_p;
        clears_on = 1'b0;
      end
      hltmr_pkg::MODE_LVL_OS_HIGH: begin
        start_ev = ers_level;
        hw_rst = ~ers_level;
      end
      hltmr_pkg::MODE_LVL_OS_LOW: begin
        start_ev = ~ers_level;
        hw_rst = ers_level;
      end
      default: begin
        reserved = 1'b1;
      end
    endcase
  end

  // A match only counts on a tick while the counter may run
  assign match = (count_value == period_value);
  assign match_ev = tick & ~reserved & on_eff & ~hw_rst & match &
                    (free_mode ? gate : (run_reg == hltmr_pkg::HLTMR_ACTIVE));
  assign hw_clr_on = match_ev & ~free_mode & clears_on;

  // Counter and run state
  always_ff @(posedge clk) begin
    if (srst) begin
      count_value <= CNT_ZERO;
      run_reg <= hltmr_pkg::HLTMR_IDLE;
    end else if (tick & ~reserved) begin
      if (free_mode) begin
        run_reg <= hltmr_pkg::HLTMR_IDLE;
        if (on_eff & hw_rst) begin
          count_value <= CNT_ZERO;
        end else if (on_eff & gate) begin
          count_value <= match ? CNT_ZERO : count_value + CNT_STEP;
        end
      end else if (run_reg == hltmr_pkg::HLTMR_IDLE) begin
        if (on_eff & hw_rst & ~keep_on_rst) begin
          count_value <= CNT_ZERO;
        end else if (on_eff & start_ev) begin
          run_reg <= hltmr_pkg::HLTMR_ACTIVE;
        end
      end else if (~on_eff) begin
        // Software one-shot only pauses; edge modes must re-arm
        if (mode_select != hltmr_pkg::MODE_OS_SW) begin
          run_reg <= hltmr_pkg::HLTMR_IDLE;
        end
      end else if (hw_rst) begin
        count_value <= CNT_ZERO;
        if (!keep_on_rst) begin
          run_reg <= hltmr_pkg::HLTMR_IDLE;
        end
      end else if (match) begin
        count_value <= CNT_ZERO;
        run_reg <= hltmr_pkg::HLTMR_IDLE;
      end else begin
        count_value <= count_value + CNT_STEP;
      end
    end
  end

  // Postscaler and output pulses
  always_ff @(posedge clk) begin
    if (srst) begin
      post_cnt_reg <= hltmr_pkg::POST_RST;
      postscaled_pulse <= 1'b0;
      period_match <= 1'b0;
    end else begin
      period_match <= match_ev;
      postscaled_pulse <= 1'b0;
      if (match_ev) begin
        if (post_cnt_reg == postscale_select) begin
          post_cnt_reg <= hltmr_pkg::POST_RST;
          postscaled_pulse <= 1'b1;
        end else begin
          post_cnt_reg <= post_cnt_reg + 4'h1;
        end
      end
    end
  end

  // Sticky flag; setting beats clearing
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_flag <= 1'b0;
    end else if (postscaled_pulse) begin
      irq_flag <= 1'b1;
    end else if (irq_flag_clr) begin
      irq_flag <= 1'b0;
    end
  end

  assign timer_irq = irq_flag & timer_irq_enable;
endmodule : hltmr_top
`default_nettype wire

// [sim/hltmr_chk.sv]
// Port checks for the period timer
`timescale 1ns/1ps
`default_nettype none
module hltmr_chk #(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Enable and configuration
  input wire logic on_wr,
  input wire logic on_wdata,
  input wire logic timer_on,
  input wire logic [hltmr_pkg::MODE_W-1:0] mode_select,
  input wire logic [CNT_W-1:0] period_value,
  // Interrupt and status
  input wire logic timer_irq_enable,
  input wire logic irq_flag_clr,
  input wire logic irq_flag,
  input wire logic timer_irq,
  input wire logic [CNT_W-1:0] count_value,
  input wire logic postscaled_pulse,
  input wire logic period_match
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  irq_gate_a: assert property (timer_irq == (irq_flag && timer_irq_enable))
    else $error("irq gating wrong");
  irq_set_a: assert property (postscaled_pulse |=> irq_flag)
    else $error("flag not set after pulse");
  irq_cause_a: assert property ($rose(irq_flag) |-> $past(postscaled_pulse))
    else $error("flag set without pulse");
  irq_hold_a: assert property (irq_flag && !irq_flag_clr |=> irq_flag)
    else $error("flag dropped");
  reset_clear_a: assert property ($fell(srst) |-> count_value == '0 && !timer_on && !irq_flag)
    else $error("reset values wrong");
  on_write_a: assert property (on_wr |=> timer_on == $past(on_wdata))
    else $error("enable write lost");
  on_cause_a: assert property ($rose(timer_on) |-> $past(on_wr))
    else $error("enable set by hardware");
  count_step_a: assert property (count_value != $past(count_value)
    |-> count_value == CNT_W'($past(count_value) + 1'b1) || count_value == '0)
    else $error("count jumped");
  match_cause_a: assert property ($rose(period_match)
    |-> $past(count_value) == period_value || $past(count_value, 2) == period_value)
    else $error("match without period count");
  oneshot_stop_a: assert property (mode_select[4:3] == 2'b01 && period_match && !$past(on_wr)
    && !$past(on_wr, 2) |-> !timer_on && count_value == '0)
    else $error("one-shot did not stop");
  mono_keep_a: assert property (mode_select[4:2] == 3'b100 && mode_select[1:0] != 2'b00 && period_match
    && !$past(on_wr) && !$past(on_wr, 2) |-> timer_on && count_value == '0)
    else $error("monostable stop wrong");
endmodule : hltmr_chk
bind hltmr_top hltmr_chk #(.CNT_W(CNT_W)) hltmr_chk_i (.clk(clk), .srst(srst), .on_wr(on_wr),
  .on_wdata(on_wdata), .timer_on(timer_on), .mode_select(mode_select), .period_value(period_value),
  .timer_irq_enable(timer_irq_enable), .irq_flag_clr(irq_flag_clr), .irq_flag(irq_flag),
  .timer_irq(timer_irq), .count_value(count_value), .postscaled_pulse(postscaled_pulse),
  .period_match(period_match));
`default_nettype wire

// [sim/hltmr_ext_src.sv]
// Trigger source model driving the external reset pin
`timescale 1ns/1ps
`default_nettype none
module hltmr_ext_src (
  // Clock
  input wire logic clk,
  // Requested and driven level
  input wire logic level_req,
  output logic ext_reset_signal
);
  logic pin_reg = 1'b0;
  logic [3:0] hold_reg = 4'hF;
  assign ext_reset_signal = pin_reg;
  // Each level stays seven clocks at least
  always_ff @(posedge clk) begin
    if (level_req != pin_reg && hold_reg >= 4'h6) begin
      pin_reg <= level_req;
      hold_reg <= 4'h0;
    end else if (hold_reg != 4'hF) begin
      hold_reg <= hold_reg + 4'h1;
    end
  end
endmodule : hltmr_ext_src
`default_nettype wire

// [sim/test_hw_limit_period_timer.sv]
// Self-checking bench for the period timer
`timescale 1ns/1ps
`default_nettype none
module test_hw_limit_period_timer;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic on_wr = 1'b0;
  logic on_wdata = 1'b0;
  logic [4:0] mode_select = 5'h00;
  logic [7:0] period_value = 8'h05;
  logic [2:0] prescale_select = 3'h0;
  logic [3:0] postscale_select = 4'h0;
  logic timer_irq_enable = 1'b0;
  logic irq_flag_clr = 1'b0;
  logic level_req = 1'b0;
  logic timer_on, irq_flag, timer_irq, postscaled_pulse, period_match, ext_reset_signal;
  logic [7:0] count_value;
  logic [7:0] c;
  logic idle;
  logic [4:0] modes [8] = '{5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h11, 5'h12, 5'h13};
  int miscompares = 0;
  int cmp_count = 0;
  int n;
  always #12.5 clk = ~clk;
  hltmr_top #(.CNT_W(8)) hltmr_top_i (.clk(clk), .srst(srst), .on_wr(on_wr), .on_wdata(on_wdata),
    .timer_on(timer_on), .mode_select(mode_select), .period_value(period_value),
    .prescale_select(prescale_select), .postscale_select(postscale_select),
    .timer_irq_enable(timer_irq_enable), .irq_flag_clr(irq_flag_clr), .irq_flag(irq_flag),
    .timer_irq(timer_irq), .ext_reset_signal(ext_reset_signal), .count_value(count_value),
    .postscaled_pulse(postscaled_pulse), .period_match(period_match));
  hltmr_ext_src hltmr_ext_src_i (.clk(clk), .level_req(level_req), .ext_reset_signal(ext_reset_signal));
  task automatic tally_and_finish();
    if (miscompares == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : step
  task automatic chk_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic chk_cnt(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_cnt
  task automatic set_on(input logic b);
    on_wr = 1'b1;
    on_wdata = b;
    step(1);
    on_wr = 1'b0;
  endtask : set_on
  task automatic rst();
    srst = 1'b1;
    step(4);
    srst = 1'b0;
  endtask : rst
  // Kind 0 count equals target, 1 period match, 2 irq flag
  task automatic wait_for(input int k, input logic [7:0] t, input int bound);
    for (int i = 0; i < bound; i++) begin
      if ((k == 0 && count_value === t) || (k == 1 && period_match === 1'b1) || (k == 2 && irq_flag === 1'b1))
        return;
      step(1);
    end
    miscompares++;
    $display("ERROR wait %0d expected hit seen timeout", k);
    tally_and_finish();
  endtask : wait_for
  initial begin
    step(10);
    srst = 1'b0;
    set_on(1'b1);
    wait_for(0, 8'h05, 20);
    step(1);
    chk_cnt("wrap", 8'h00, count_value);
    step(1);
    chk_cnt("rerun", 8'h01, count_value);
    postscale_select = 4'h2;
    wait_for(2, 8'h00, 100);
    chk_bit("irq masked", 1'b0, timer_irq);
    timer_irq_enable = 1'b1;
    irq_flag_clr = 1'b1;
    step(1);
    irq_flag_clr = 1'b0;
    chk_bit("flag clr", 1'b0, irq_flag);
    for (n = 1; n < 40 && irq_flag !== 1'b1; n++) step(1);
    chk_cnt("ratio", 8'd18, 8'(n));
    chk_bit("irq on", 1'b1, timer_irq);
    set_on(1'b0);
    step(4);
    c = count_value;
    step(4);
    chk_cnt("hold", c, count_value);
    rst();
    mode_select = 5'h08;
    set_on(1'b1);
    wait_for(1, 8'h00, 30);
    step(2);
    chk_bit("os on", 1'b0, timer_on);
    chk_cnt("os cnt", 8'h00, count_value);
    set_on(1'b1);
    step(5);
    set_on(1'b0);
    step(6);
    c = count_value;
    step(3);
    chk_cnt("os pause", c, count_value);
    chk_bit("os mid", 1'b1, c != 8'h00);
    set_on(1'b1);
    wait_for(1, 8'h00, 7);
    rst();
    mode_select = 5'h04;
    period_value = 8'hC8;
    set_on(1'b1);
    step(40);
    level_req = 1'b1;
    wait_for(0, 8'h00, 12);
    step(4);
    chk_bit("hl run", 1'b1, count_value != 8'h00);
    rst();
    mode_select = 5'h01;
    // Let the synchroniser settle on the pin's level
    step(6);
    set_on(1'b1);
    step(10);
    chk_cnt("gate hi", 8'h00, count_value);
    level_req = 1'b0;
    wait_for(0, 8'h03, 20);
    rst();
    mode_select = 5'h07;
    set_on(1'b1);
    step(20);
    level_req = 1'b1;
    step(8);
    chk_cnt("lvl rst", 8'h00, count_value);
    level_req = 1'b0;
    wait_for(0, 8'h01, 10);
    rst();
    mode_select = 5'h00;
    prescale_select = 3'h1;
    set_on(1'b1);
    wait_for(0, 8'h02, 20);
    step(1);
    chk_cnt("pre hold", 8'h02, count_value);
    step(1);
    chk_cnt("pre step", 8'h03, count_value);
    prescale_select = 3'h0;
    rst();
    mode_select = 5'h10;
    set_on(1'b1);
    step(10);
    chk_cnt("reserved", 8'h00, count_value);
    rst();
    mode_select = 5'h16;
    period_value = 8'h05;
    set_on(1'b1);
    step(8);
    chk_cnt("lvl os held", 8'h00, count_value);
    level_req = 1'b1;
    wait_for(1, 8'h00, 20);
    step(2);
    chk_bit("lvl os on", 1'b0, timer_on);
    chk_cnt("lvl os cnt", 8'h00, count_value);
    for (int i = 0; i < 8; i++) begin
      rst();
      idle = modes[i] == 5'h0A || modes[i] == 5'h0D || modes[i] == 5'h12;
      level_req = idle;
      step(8);
      mode_select = modes[i];
      period_value = 8'h05;
      set_on(1'b1);
      step(8);
      chk_cnt("no edge", 8'h00, count_value);
      level_req = ~idle;
      wait_for(1, 8'h00, 40);
      step(2);
      chk_bit("match on", modes[i][4], timer_on);
      chk_cnt("match cnt", 8'h00, count_value);
      set_on(1'b1);
      step(8);
      chk_cnt("need edge", 8'h00, count_value);
    end
    tally_and_finish();
  end
endmodule : test_hw_limit_period_timer
`default_nettype wire
